// >>> adcc_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit Avalon-MM word per register, byte addresses
// Notes:   definitions only
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define ADCC_OFS_CTRL0      4'h0
`define ADCC_OFS_REFCTL     4'h4
`define ADCC_OFS_TIMFMT     4'h8
`define ADCC_OFS_RESHI      4'hc
`define ADCC_OFS_RESLO      4'h0
`define ADCC_OFS_STATUS     4'h4
`define ADCC_PAGE_LO        1'b0
`define ADCC_PAGE_HI        1'b1

// ****************************************
// field positions and reset values
// ****************************************
`define ADCC_CTRL0_MASK     8'h3f
`define ADCC_REFCTL_MASK    8'h30
`define ADCC_TIMFMT_MASK    8'hbf
`define ADCC_BIT_START      1
`define ADCC_BIT_ENABLE     0
`define ADCC_CHAN_FVR       4'hf
`define ADCC_CHAN_LAST      4'hc
`define ADCC_RESET_BYTE     8'h00

// ****************************************
// timing
// ****************************************
`define ADCC_RESULT_BITS    4'ha
`define ADCC_GAP_TADS       5'h02
`define ADCC_FRC_KHZ        600
`define ADCC_CLK_KHZ        200000
`define ADCC_FRC_DIV        (`ADCC_CLK_KHZ / `ADCC_FRC_KHZ)
`define ADCC_ICYCLE_CLKS    8'h04

`endif

// >>> adcc_pkg.sv
// Purpose: shared types of the converter control block
// Assumes: nothing
// Notes:   no constants here, see adcc_regs.svh
package adcc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_HOLDOFF, ST_ACQ, ST_CONV, ST_GAP} adcc_state_t;
endpackage

// >>> adcc_tad_gen.sv
// Purpose: conversion clock enable from system clock or internal oscillator
// Assumes: one clock mclk; oscillator modelled as a divider
// Notes:   pulse is one mclk cycle wide
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_tad_gen #(
  parameter int FRC_DIV = `ADCC_FRC_DIV
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] clk_sel,
  output logic            tad_tick
);
  logic [9:0] cnt;
  logic [9:0] limit;

  // ****************************************
  // divider limits
  // ****************************************
  function automatic logic [9:0] div_limit(input logic [2:0] sel);
    case (sel)
      3'h0: div_limit = 10'h001;
      3'h4: div_limit = 10'h003;
      3'h1: div_limit = 10'h007;
      3'h5: div_limit = 10'h00f;
      3'h2: div_limit = 10'h01f;
      3'h6: div_limit = 10'h03f;
      default: div_limit = 10'(FRC_DIV - 1);
    endcase
  endfunction

  assign limit = div_limit(clk_sel);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt      <= 10'h000;
      tad_tick <= 1'b0;
    end else if (!run) begin
      cnt      <= 10'h000;
      tad_tick <= 1'b0;
    end else if (cnt >= limit) begin
      cnt      <= 10'h000;
      tad_tick <= 1'b1;
    end else begin
      cnt      <= cnt + 10'h001;
      tad_tick <= 1'b0;
    end
  end
endmodule // adcc_tad_gen

// >>> adcc_control.sv
// Purpose: converter control, sequencing and result registers
// Assumes: Avalon-MM slave, 32-bit data, one register per word
// Notes:   comparator answer comes from the analog core each conversion clock
//
// Overview of operation
// - channel codes 0-12 inputs, 15 fixed reference
// - writing start begins conversion, reads busy
// - hardware clears start bit at finish
// - enable clear disables converter, no current
// - unimplemented control bits read as zero
// - bit 5 selects external negative reference
// - bit 4 selects external positive reference
// - justify bit: one right, zero left
// - acquisition field sets automatic delay length
// - sample switch closed during acquisition delay
// - clock field divides system clock
// - codes 011/111 select internal oscillator
// - oscillator clock delays start one instruction
// - left layout: high 9-2, low 1-0
// - right layout: high byte bits 9-8
// - finish clears start, flags, writes result
// - clearing start aborts, keeps old result
// - two conversion clocks before next acquisition
// - right layout: low byte bits 7-0
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_control #(
  parameter int FRC_DIV = `ADCC_FRC_DIV
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        comp_high,
  output logic [3:0]       channel_select,
  output logic             sample_connect,
  output logic [9:0]       trial_code,
  output logic             converter_power,
  output logic             negative_ref_select,
  output logic             positive_ref_select,
  output logic             converter_irq_flag
);
  logic [3:0]          ctrl_chan;
  logic                ctrl_start;
  logic                converter_enable;
  logic                neg_ref;
  logic                pos_ref;
  logic                result_justify;
  logic [2:0]          acquisition_delay_select;
  logic [2:0]          conversion_clock_select;
  logic [7:0]          result_high_byte;
  logic [7:0]          result_low_byte;
  logic                page;
  adcc_pkg::adcc_state_t state;
  logic [4:0]          tad_cnt;
  logic [7:0]          hold_cnt;
  logic [9:0]          sar;
  logic [3:0]          bit_idx;
  logic                tad_tick;
  logic                done_evt;
  logic                abort_evt;
  logic                wr_acc;
  logic                rd_acc;
  logic                start_wr;
  logic                stop_wr;
  logic                comp_val;
  logic [9:0]          next_sar;

  assign wr_acc   = write && !waitrequest;
  assign rd_acc   = read && !waitrequest;
  assign start_wr = wr_acc && !page && address == `ADCC_OFS_CTRL0 && byteenable[0]
                    && writedata[`ADCC_BIT_START];
  assign stop_wr  = wr_acc && !page && address == `ADCC_OFS_CTRL0 && byteenable[0]
                    && !writedata[`ADCC_BIT_START];
  assign abort_evt = (stop_wr || !converter_enable) && state != adcc_pkg::ST_IDLE
                     && state != adcc_pkg::ST_GAP;

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h0: acq_tads = 5'h00;
      3'h1: acq_tads = 5'h02;
      3'h2: acq_tads = 5'h04;
      3'h3: acq_tads = 5'h06;
      3'h4: acq_tads = 5'h08;
      3'h5: acq_tads = 5'h0c;
      3'h6: acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction

  function automatic logic is_frc(input logic [2:0] code);
    is_frc = code[1] && code[0];
  endfunction

  // ****************************************
  // conversion clock enable
  // ****************************************
  adcc_tad_gen #(.FRC_DIV(FRC_DIV)) u_tad (
    .mclk     (mclk),
    .rst      (rst),
    .run      (converter_enable),
    .clk_sel  (conversion_clock_select),
    .tad_tick (tad_tick)
  );

  // ****************************************
  // comparator input
  // ****************************************
  // settles off the registered trial word within one clock;
  // a synchroniser would outlast the fastest bit time
  assign comp_val = comp_high;

  // ****************************************
  // bus handshake, one wait cycle per access
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_chan                <= 4'h0;
      converter_enable         <= 1'b0;
      neg_ref                  <= 1'b0;
      pos_ref                  <= 1'b0;
      result_justify           <= 1'b0;
      acquisition_delay_select <= 3'h0;
      conversion_clock_select  <= 3'h0;
      page                     <= `ADCC_PAGE_LO;
    end else if (wr_acc && byteenable[0]) begin
      if (!page && address == `ADCC_OFS_CTRL0) begin
        ctrl_chan        <= writedata[5:2];
        converter_enable <= writedata[`ADCC_BIT_ENABLE];
      end else if (!page && address == `ADCC_OFS_REFCTL) begin
        neg_ref <= writedata[5];
        pos_ref <= writedata[4];
      end else if (!page && address == `ADCC_OFS_TIMFMT) begin
        result_justify           <= writedata[7];
        acquisition_delay_select <= writedata[5:3];
        conversion_clock_select  <= writedata[2:0];
      end else if (address == `ADCC_OFS_RESHI) begin
        page <= writedata[0];
      end
    end
  end

  // ****************************************
  // start/done bit
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_start <= 1'b0;
    end else if (done_evt || abort_evt || stop_wr) begin
      ctrl_start <= 1'b0;
    end else if (start_wr && converter_enable && state == adcc_pkg::ST_IDLE) begin
      ctrl_start <= 1'b1;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    next_sar = sar;
    if (comp_val) begin
      next_sar[bit_idx] = 1'b0;
    end
    if (bit_idx != 4'h0) begin
      next_sar[bit_idx - 4'h1] = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state    <= adcc_pkg::ST_IDLE;
      tad_cnt  <= 5'h00;
      hold_cnt <= 8'h00;
      sar      <= 10'h000;
      bit_idx  <= 4'h0;
      done_evt <= 1'b0;
    end else begin
      done_evt <= 1'b0;
      if (abort_evt) begin
        state   <= adcc_pkg::ST_GAP;
        tad_cnt <= 5'h00;
      end else begin
        case (state)
          adcc_pkg::ST_IDLE: begin
            if (start_wr && converter_enable) begin
              hold_cnt <= `ADCC_ICYCLE_CLKS;
              tad_cnt  <= 5'h00;
              state    <= is_frc(conversion_clock_select) ? adcc_pkg::ST_HOLDOFF : adcc_pkg::ST_ACQ;
            end
          end
          adcc_pkg::ST_HOLDOFF: begin
            if (hold_cnt <= 8'h01) begin
              state <= adcc_pkg::ST_ACQ;
            end else begin
              hold_cnt <= hold_cnt - 8'h01;
            end
          end
          adcc_pkg::ST_ACQ: begin
            // enter conversion on a tick so the first trial settles
            if (tad_tick && tad_cnt >= acq_tads(acquisition_delay_select)) begin
              state   <= adcc_pkg::ST_CONV;
              sar     <= 10'h200;
              bit_idx <= 4'h9;
            end else if (tad_tick) begin
              tad_cnt <= tad_cnt + 5'h01;
            end
          end
          adcc_pkg::ST_CONV: begin
            if (tad_tick) begin
              sar <= next_sar;
              if (bit_idx == 4'h0) begin
                done_evt <= 1'b1;
                state    <= adcc_pkg::ST_GAP;
                tad_cnt  <= 5'h00;
              end else begin
                bit_idx <= bit_idx - 4'h1;
              end
            end
          end
          adcc_pkg::ST_GAP: begin
            if (tad_cnt >= `ADCC_GAP_TADS || !converter_enable) begin
              state <= adcc_pkg::ST_IDLE;
            end else if (tad_tick) begin
              tad_cnt <= tad_cnt + 5'h01;
            end
          end
          default: state <= adcc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // result pair and flag
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_high_byte <= `ADCC_RESET_BYTE;
      result_low_byte  <= `ADCC_RESET_BYTE;
    end else if (done_evt) begin
      if (result_justify) begin
        result_high_byte <= {6'h00, sar[9:8]};
        result_low_byte  <= sar[7:0];
      end else begin
        result_high_byte <= sar[9:2];
        result_low_byte  <= {sar[1:0], 6'h00};
      end
    end else if (wr_acc && byteenable[0] && !page && address == `ADCC_OFS_RESHI) begin
      result_high_byte <= writedata[7:0];
    end else if (wr_acc && byteenable[0] && page && address == `ADCC_OFS_RESLO) begin
      result_low_byte <= writedata[7:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      converter_irq_flag <= 1'b0;
    end else if (done_evt) begin
      converter_irq_flag <= 1'b1;
    end else if (wr_acc && byteenable[0] && page && address == `ADCC_OFS_STATUS && writedata[0]) begin
      converter_irq_flag <= 1'b0;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      if (!page && address == `ADCC_OFS_CTRL0) begin
        readdata <= {24'h0, 2'b00, ctrl_chan, ctrl_start, converter_enable};
      end else if (!page && address == `ADCC_OFS_REFCTL) begin
        readdata <= {24'h0, 2'b00, neg_ref, pos_ref, 4'h0};
      end else if (!page && address == `ADCC_OFS_TIMFMT) begin
        readdata <= {24'h0, result_justify, 1'b0, acquisition_delay_select, conversion_clock_select};
      end else if (!page && address == `ADCC_OFS_RESHI) begin
        readdata <= {24'h0, result_high_byte};
      end else if (page && address == `ADCC_OFS_RESLO) begin
        readdata <= {24'h0, result_low_byte};
      end else if (page && address == `ADCC_OFS_STATUS) begin
        readdata <= {28'h0, 1'b0, 2'(state), converter_irq_flag};
      end else if (page && address == `ADCC_OFS_RESHI) begin
        readdata <= {31'h0, page};
      end else begin
        readdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // analog core controls
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      channel_select      <= 4'h0;
      sample_connect      <= 1'b0;
      trial_code          <= 10'h000;
      converter_power     <= 1'b0;
      negative_ref_select <= 1'b0;
      positive_ref_select <= 1'b0;
    end else begin
      channel_select      <= ctrl_chan;
      sample_connect      <= converter_enable && (state == adcc_pkg::ST_IDLE || state == adcc_pkg::ST_HOLDOFF
                             || state == adcc_pkg::ST_ACQ);
      trial_code          <= sar;
      converter_power     <= converter_enable;
      negative_ref_select <= neg_ref;
      positive_ref_select <= pos_ref;
    end
  end
endmodule // adcc_control

// >>> adcc_analog_model.sv
// Purpose: analog mux, hold capacitor and comparator stand-in
// Assumes: channel level is {channel, 6'h25} plus half an lsb
// Notes:   comparator wanders while the converter is off
`timescale 1ns/1ps
module adcc_analog_model (
  input  wire logic       mclk,
  input  wire logic [9:0] trial_code,
  input  wire logic [3:0] channel_select,
  input  wire logic       sample_connect,
  input  wire logic       converter_power,
  output logic            comp_high
);
  logic [9:0] held;
  logic       wander = 1'b0;
  always_ff @(posedge mclk) begin
    wander <= ~wander;
    if (sample_connect) held <= {channel_select, 6'h25};
  end
  assign comp_high = converter_power ? (trial_code > held) : wander;
endmodule // adcc_analog_model

// >>> adcc_control_chk.sv
// Purpose: port assertions of the converter control block
// Assumes: register page tracked from taken writes at offset c
// Notes:   bound into adcc_control
`timescale 1ns/1ps
module adcc_control_chk #(
  parameter int FRC_DIV = 4
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [3:0]  channel_select,
  input wire logic        sample_connect,
  input wire logic        converter_power,
  input wire logic        negative_ref_select,
  input wire logic        positive_ref_select,
  input wire logic        converter_irq_flag
);
  logic       page;
  logic [5:0] low_cnt;
  logic       wr_ok;
  logic       rd_ok;
  assign wr_ok = write && !waitrequest;
  assign rd_ok = read && !waitrequest;
  // ****
  // helper state
  // ****
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) page <= 1'b0;
    else if (wr_ok && address == 4'hc) page <= writedata[0];
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) low_cnt <= 6'h00;
    else if (sample_connect) low_cnt <= 6'h00;
    else if (low_cnt != 6'h3f) low_cnt <= low_cnt + 6'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ****
  // assertions
  // ****
  a_enable_power: assert property (wr_ok && address == 4'h0 && !page |-> ##2 converter_power == $past(writedata[0], 2))
    else $error("power does not follow enable");
  a_chan_route: assert property (wr_ok && address == 4'h0 && !page |-> ##2 channel_select == $past(writedata[5:2], 2))
    else $error("channel port wrong");
  a_ref_select: assert property (wr_ok && address == 4'h4 && !page |-> ##2
    {negative_ref_select, positive_ref_select} == $past(writedata[5:4], 2))
    else $error("reference ports wrong");
  a_unimpl_zero: assert property (rd_ok && !page && address != 4'hc |-> !readdata[6] &&
    (address == 4'h8 || !readdata[7]) && (address != 4'h4 || readdata[3:0] == 4'h0))
    else $error("unimplemented bit reads one");
  a_off_idle: assert property (!converter_power [*2] |-> !sample_connect)
    else $error("sampling while off");
  a_conv_length: assert property ($rose(converter_irq_flag) |-> low_cnt >= 6'h13)
    else $error("done before ten bit times");
  a_gap_hold: assert property ($rose(converter_irq_flag) |-> !sample_connect [*3])
    else $error("sampling resumed without gap");
  a_irq_sticky: assert property ($fell(converter_irq_flag) |->
    $past(wr_ok && address == 4'h4 && page && writedata[0]))
    else $error("flag dropped by itself");
  c_done: cover property ($rose(converter_irq_flag));
  c_conv: cover property ($fell(sample_connect));
  c_clear: cover property (wr_ok && address == 4'h4 && page);
endmodule // adcc_control_chk

bind adcc_control adcc_control_chk #(.FRC_DIV(FRC_DIV)) i_adcc_control_chk (
  .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .channel_select(channel_select), .sample_connect(sample_connect),
  .converter_power(converter_power), .negative_ref_select(negative_ref_select),
  .positive_ref_select(positive_ref_select), .converter_irq_flag(converter_irq_flag));

// >>> adcc_control_test.sv
// Purpose: register-level tests of the converter control block
// Assumes: oscillator divider of 4 mclk periods
// Notes:   expected codes follow the analog stand-in levels
`timescale 1ns/1ps
module adcc_control_test;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q, hp;
  logic        waitrequest, comp_high, sample_connect, converter_power, converter_irq_flag;
  logic        negative_ref_select, positive_ref_select;
  logic [3:0]  channel_select, ch;
  logic [9:0]  trial_code, v;
  logic [2:0]  ka;
  int          fail_count = 0;
  int          compares = 0;
  int          cyc = 0;
  int          t0, t1, d, hold;
  int          acq_t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  adcc_control #(.FRC_DIV(4)) i_adcc_control (
    .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
    .comp_high(comp_high), .channel_select(channel_select), .sample_connect(sample_connect),
    .trial_code(trial_code), .converter_power(converter_power),
    .negative_ref_select(negative_ref_select), .positive_ref_select(positive_ref_select),
    .converter_irq_flag(converter_irq_flag));
  adcc_analog_model i_adcc_analog_model (
    .mclk(mclk), .trial_code(trial_code), .channel_select(channel_select),
    .sample_connect(sample_connect), .converter_power(converter_power), .comp_high(comp_high));

  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  // ****
  // tasks
  // ****
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  task automatic rng(input int n, input int lo, input int hi);
    compares++;
    if (n < lo || n > hi) begin
      fail_count++;
      $display("unexpected at %0t: %0d cycles, not in %0d..%0d", $time, n, lo, hi);
    end
  endtask
  task automatic hang(input string m);
    fail_count++;
    $display("unexpected at %0t: timeout %s", $time, m);
    report_and_stop();
  endtask
  task automatic tend(input string m);
    $display("test %s done", m);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= wd;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    r = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (waitrequest !== 1'b0) hang("bus");
  endtask
  task automatic wait_sc(input logic lvl);
    int n;
    n = 0;
    while (sample_connect !== lvl && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    if (sample_connect !== lvl) hang("sample");
  endtask
  function automatic int div_of(input logic [2:0] c);
    case (c)
      3'h0: return 2;
      3'h4: return 4;
      3'h1: return 8;
      3'h5: return 16;
      3'h2: return 32;
      3'h6: return 64;
      default: return 4;
    endcase
  endfunction
  // ****
  // tests
  // ****
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 12; a += 4) begin
      bus(1'b0, 4'(a), 32'h0, q);
      chk(q, 32'h0, "reset value");
    end
    bus(1'b1, 4'h0, 32'hffff_fffd, q);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h3d, "ctl0 bits");
    chk({28'h0, channel_select}, 32'hf, "chan port");
    chk({31'h0, converter_power}, 32'h1, "power");
    bus(1'b1, 4'h4, 32'hff, q);
    bus(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h30, "ref bits");
    bus(1'b1, 4'h4, 32'h20, q);
    @(posedge mclk);
    @(negedge mclk);
    chk({30'h0, negative_ref_select, positive_ref_select}, 32'h2, "ref ports");
    bus(1'b1, 4'h8, 32'hff, q);
    bus(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'hbf, "timing bits");
    bus(1'b1, 4'hc, 32'h1, q);
    bus(1'b1, 4'h8, 32'hff, q);
    bus(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    bus(1'b1, 4'hc, 32'h0, q);
    tend("registers");
    for (int k = 0; k < 8; k++) begin
      ka = 3'(k);
      ch = (k == 7) ? 4'hf : (k == 6) ? 4'hc : 4'(k);
      v = {ch, 6'h25};
      d = div_of(ka);
      hold = (ka[1:0] == 2'b11) ? 4 : 0;
      bus(1'b1, 4'h8, {24'h0, ka[0], 1'b0, ka, ka}, q);
      bus(1'b1, 4'h0, {24'h0, 2'b00, ch, 2'b01}, q);
      repeat (20) @(posedge mclk);
      bus(1'b1, 4'h0, {24'h0, 2'b00, ch, 2'b11}, q);
      t0 = cyc;
      wait_sc(1'b0);
      t1 = cyc;
      rng(t1 - t0, acq_t[k] * d + hold, acq_t[k] * d + hold + d + 3);
      bus(1'b0, 4'h0, 32'h0, q);
      chk(q & 32'h2, 32'h2, "busy");
      wait_sc(1'b1);
      rng(cyc - t1, 12 * d - 2, 13 * d);
      bus(1'b0, 4'h0, 32'h0, q);
      chk(q & 32'h2, 32'h0, "done");
      chk({31'h0, converter_irq_flag}, 32'h1, "flag");
      bus(1'b0, 4'hc, 32'h0, q);
      chk(q & (ka[0] ? 32'h3 : 32'hff), ka[0] ? {30'h0, v[9:8]} : {24'h0, v[9:2]}, "high");
      bus(1'b1, 4'hc, 32'h1, q);
      bus(1'b0, 4'h0, 32'h0, q);
      chk(q & (ka[0] ? 32'hff : 32'hc0), ka[0] ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0}, "low");
      bus(1'b1, 4'h4, 32'h1, q);
      bus(1'b0, 4'h4, 32'h0, q);
      chk(q & 32'h1, 32'h0, "flag clear");
      bus(1'b1, 4'hc, 32'h0, q);
    end
    tend("conversions");
    bus(1'b1, 4'h8, 32'h1, q);
    bus(1'b0, 4'hc, 32'h0, hp);
    bus(1'b1, 4'h0, 32'h7, q);
    wait_sc(1'b0);
    bus(1'b1, 4'h0, 32'h5, q);
    bus(1'b1, 4'h0, 32'h7, q);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h5, "gap start");
    bus(1'b0, 4'hc, 32'h0, q);
    chk(q, hp, "kept");
    chk({31'h0, converter_irq_flag}, 32'h0, "abort flag");
    tend("abort");
    bus(1'b1, 4'h0, 32'h0, q);
    bus(1'b1, 4'h0, 32'h2, q);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0, "off start");
    chk({30'h0, converter_power, sample_connect}, 32'h0, "off ports");
    tend("disable");
    bus(1'b1, 4'h0, 32'h1, q);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0, "after reset");
    tend("reset");
    report_and_stop();
  end
endmodule // adcc_control_test
